// ==== hw/tfrl_pkg.sv ====
/*
 Package for the temperature fault retry and limit block: command codes,
 field positions of the hot fault reaction byte, reset values and codes.
 Assumes the enclosing converter decodes the serial bus into command
 strobes with an eight-bit command code and sixteen-bit data.
*/
package tfrl_pkg;
	// ------------------------------------------------------------
	// Command codes
	// ------------------------------------------------------------
	localparam logic [7:0] CMD_HOT_WARN   = 8'h51;
	localparam logic [7:0] CMD_COLD_WARN  = 8'h52;
	localparam logic [7:0] CMD_COLD_FAULT = 8'h53;
	localparam logic [7:0] CMD_HOT_REACT  = 8'h50;

	// ------------------------------------------------------------
	// Reaction byte fields
	// ------------------------------------------------------------
	localparam int RESP_HI  = 7;
	localparam int RESP_LO  = 6;
	localparam int RETRY_HI = 5;
	localparam int RETRY_LO = 3;
	localparam int TIME_HI  = 2;
	localparam int TIME_LO  = 0;

	localparam logic [1:0] RESP_IGNORE   = 2'h0;
	localparam logic [1:0] RESP_RUN_WAIT = 2'h1;
	localparam logic [1:0] RESP_RETRY    = 2'h2;
	localparam logic [1:0] RESP_LATCH    = 2'h3;

	localparam logic [2:0] RETRY_NONE    = 3'h0;
	localparam logic [2:0] RETRY_FOREVER = 3'h7;

	// ------------------------------------------------------------
	// Reset values (no values given: chosen neutral)
	// ------------------------------------------------------------
	localparam logic [15:0] RST_HOT_WARN   = 16'h0000;
	localparam logic [15:0] RST_COLD_WARN  = 16'h0000;
	localparam logic [15:0] RST_COLD_FAULT = 16'h0000;
	localparam logic [7:0]  RST_HOT_REACT  = 8'h80;

	// Widest count of delay units is 2**7
	localparam int UNIT_CNT_W = 8;

	typedef enum logic [2:0] {
		ST_RUN,
		ST_RUN_WAIT,
		ST_OFF_WAIT,
		ST_RESTART,
		ST_LATCHED
	} tfrl_state_t;
endpackage

// ==== hw/tfrl_reg_if.sv ====
/*
 Interface carrying the register bank's values to the fault sequencer.
 Assumes one clock domain; registers are written by the bank only.
*/
`timescale 1ns/1ns
interface tfrl_reg_if;
	logic [15:0] hot_warn;
	logic [15:0] cold_warn;
	logic [15:0] cold_fault;
	logic [7:0]  hot_react;

	modport bank (output hot_warn, output cold_warn, output cold_fault,
		output hot_react);
	modport user (input hot_warn, input cold_warn, input cold_fault,
		input hot_react);
endinterface

// ==== hw/tfrl_reg_bank.sv ====
/*
 Register bank: the three temperature limits and the hot fault reaction
 byte, written and read by command code. Read data come from a register.
 Assumes command strobes are one-cycle pulses in the clk domain.
*/
`timescale 1ns/1ns
module tfrl_reg_bank (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        wr_stb,
	input  wire logic        rd_stb,
	input  wire logic [7:0]  cmd,
	input  wire logic [15:0] wdata,
	output logic      [15:0] rdata_ff,
	output logic             ack_ff,
	tfrl_reg_if.bank         regs
);
	always_ff @(posedge clk) begin
		if (rst) begin
			regs.hot_warn   <= tfrl_pkg::RST_HOT_WARN;
			regs.cold_warn  <= tfrl_pkg::RST_COLD_WARN;
			regs.cold_fault <= tfrl_pkg::RST_COLD_FAULT;
			regs.hot_react  <= tfrl_pkg::RST_HOT_REACT;
		end else if (wr_stb) begin
			unique case (cmd)
				tfrl_pkg::CMD_HOT_WARN:   regs.hot_warn <= wdata;
				tfrl_pkg::CMD_COLD_WARN:  regs.cold_warn <= wdata;
				tfrl_pkg::CMD_COLD_FAULT: regs.cold_fault <= wdata;
				tfrl_pkg::CMD_HOT_REACT:  regs.hot_react <= wdata[7:0];
				default: ;
			endcase
		end
	end

	// Unmapped codes read zero and are not acknowledged
	always_ff @(posedge clk) begin
		if (rst) begin
			rdata_ff <= 16'h0000;
			ack_ff   <= 1'b0;
		end else begin
			ack_ff <= 1'b0;
			if (rd_stb || wr_stb) begin
				ack_ff <= (cmd == tfrl_pkg::CMD_HOT_WARN) ||
					(cmd == tfrl_pkg::CMD_COLD_WARN) ||
					(cmd == tfrl_pkg::CMD_COLD_FAULT) ||
					(cmd == tfrl_pkg::CMD_HOT_REACT);
			end
			if (rd_stb) begin
				unique case (cmd)
					tfrl_pkg::CMD_HOT_WARN:   rdata_ff <= regs.hot_warn;
					tfrl_pkg::CMD_COLD_WARN:  rdata_ff <= regs.cold_warn;
					tfrl_pkg::CMD_COLD_FAULT: rdata_ff <= regs.cold_fault;
					tfrl_pkg::CMD_HOT_REACT:
						rdata_ff <= {8'h00, regs.hot_react};
					default: rdata_ff <= 16'h0000;
				endcase
			end
		end
	end
endmodule

// ==== hw/tfrl_top.sv ====
/*
 Temperature fault retry and limit logic of a managed power converter.
 Holds the limit registers, compares the measured temperature, and
 sequences the hot fault reaction: ignore, run-then-check, disable with
 counted or endless restarts, or latch off until cleared.
 Assumes fault and command inputs come from logic on clk, the linear
 temperature is compared as a signed word by the converter's own scaling,
 and the delay unit arrives as a one-cycle tick from the timing register.
*/
`timescale 1ns/1ns

module tfrl_top (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        wr_stb,
	input  wire logic        rd_stb,
	input  wire logic [7:0]  cmd,
	input  wire logic [15:0] wdata,
	output logic      [15:0] rdata,
	output logic             ack,
	input  wire logic [15:0] temp_now,
	input  wire logic        temp_valid,
	input  wire logic        hot_fault,
	input  wire logic        unit_tick,
	input  wire logic        restart_ok,
	input  wire logic        on_cmd,
	input  wire logic        bias_ok,
	input  wire logic        other_fault,
	input  wire logic        clear_faults,
	input  wire logic        clear_hot_bit,
	output logic             out_enable,
	output logic             restart_stb,
	output logic             hot_fault_flag,
	output logic             hot_warn_flag,
	output logic             cold_warn_flag,
	output logic             cold_fault_flag
);
	// ------------------------------------------------------------
	// Register bank
	// ------------------------------------------------------------
	tfrl_reg_if regs ();

	tfrl_reg_bank i_tfrl_reg_bank (
		.clk      (clk),
		.rst      (rst),
		.wr_stb   (wr_stb),
		.rd_stb   (rd_stb),
		.cmd      (cmd),
		.wdata    (wdata),
		.rdata_ff (rdata),
		.ack_ff   (ack),
		.regs     (regs.bank)
	);

	// ------------------------------------------------------------
	// Field decode
	// ------------------------------------------------------------
	logic [1:0] resp;
	logic [2:0] retry_code;
	logic [2:0] time_code;

	assign resp       = regs.hot_react[tfrl_pkg::RESP_HI:tfrl_pkg::RESP_LO];
	assign retry_code =
		regs.hot_react[tfrl_pkg::RETRY_HI:tfrl_pkg::RETRY_LO];
	assign time_code  = regs.hot_react[tfrl_pkg::TIME_HI:tfrl_pkg::TIME_LO];

	// Two to the field value: 1,2,4,...,128 units
	function automatic logic [tfrl_pkg::UNIT_CNT_W-1:0] units_of(
		input logic [2:0] code);
		logic [tfrl_pkg::UNIT_CNT_W-1:0] one;
		one = {{(tfrl_pkg::UNIT_CNT_W-1){1'b0}}, 1'b1};
		units_of = one << code;
	endfunction

	// ------------------------------------------------------------
	// Warning and cold comparisons
	// ------------------------------------------------------------
	// Flags only report; they never touch out_enable
	always_ff @(posedge clk) begin
		if (rst) begin
			hot_warn_flag   <= 1'b0;
			cold_warn_flag  <= 1'b0;
			cold_fault_flag <= 1'b0;
		end else begin
			if (temp_valid &&
			    $signed(temp_now) >= $signed(regs.hot_warn)) begin
				hot_warn_flag <= 1'b1;
			end else if (clear_faults) begin
				hot_warn_flag <= 1'b0;
			end
			if (temp_valid &&
			    $signed(temp_now) <= $signed(regs.cold_warn)) begin
				cold_warn_flag <= 1'b1;
			end else if (clear_faults) begin
				cold_warn_flag <= 1'b0;
			end
			if (temp_valid &&
			    $signed(temp_now) <= $signed(regs.cold_fault)) begin
				cold_fault_flag <= 1'b1;
			end else if (clear_faults) begin
				cold_fault_flag <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// Off-then-on detection
	// ------------------------------------------------------------
	logic on_cmd_ff;
	logic off_seen_ff;
	logic clear_req;

	always_ff @(posedge clk) begin
		if (rst) begin
			on_cmd_ff   <= 1'b0;
			off_seen_ff <= 1'b0;
		end else begin
			on_cmd_ff <= on_cmd;
			if (!on_cmd) begin
				off_seen_ff <= 1'b1;
			end else if (on_cmd_ff) begin
				off_seen_ff <= 1'b0;
			end
		end
	end

	// Clear sources; reset itself clears through the state reset
	// Edge needs a seen-off, so on_cmd_ff low after reset is no clear
	assign clear_req = clear_hot_bit || clear_faults || !bias_ok ||
		(on_cmd && !on_cmd_ff && off_seen_ff);

	// ------------------------------------------------------------
	// Delay timer: counts unit ticks from the timing register
	// ------------------------------------------------------------
	logic [tfrl_pkg::UNIT_CNT_W:0] timer_ff;
	logic                          timer_load;
	logic                          timer_done;

	assign timer_done = (timer_ff == '0);

	always_ff @(posedge clk) begin
		if (rst) begin
			timer_ff <= '0;
		end else if (timer_load) begin
			timer_ff <= {1'b0, units_of(time_code)};
		end else if (unit_tick && !timer_done) begin
			timer_ff <= timer_ff - 1'b1;
		end
	end

	// ------------------------------------------------------------
	// Fault sequencer
	// ------------------------------------------------------------
	tfrl_pkg::tfrl_state_t state_ff;
	tfrl_pkg::tfrl_state_t nxt_state;
	logic [2:0]            tries_ff;
	logic                  tries_clr;
	logic                  tries_inc;
	logic                  retry_left;

	// 111 never runs out; others allow as many tries as the code
	assign retry_left = (retry_code == tfrl_pkg::RETRY_FOREVER) ||
		(tries_ff < retry_code);

	always_comb begin
		nxt_state  = state_ff;
		timer_load = 1'b0;
		tries_clr  = 1'b0;
		tries_inc  = 1'b0;
		unique case (state_ff)
			tfrl_pkg::ST_RUN: begin
				tries_clr = 1'b1;
				if (hot_fault) begin
					unique case (resp)
						tfrl_pkg::RESP_IGNORE: ;
						tfrl_pkg::RESP_RUN_WAIT: begin
							nxt_state  = tfrl_pkg::ST_RUN_WAIT;
							timer_load = 1'b1;
						end
						tfrl_pkg::RESP_RETRY: begin
							nxt_state  = tfrl_pkg::ST_OFF_WAIT;
							timer_load = 1'b1;
						end
						tfrl_pkg::RESP_LATCH:
							nxt_state = tfrl_pkg::ST_LATCHED;
					endcase
				end
			end
			tfrl_pkg::ST_RUN_WAIT: begin
				if (timer_done) begin
					if (!hot_fault) begin
						nxt_state = tfrl_pkg::ST_RUN;
					end else begin
						nxt_state  = tfrl_pkg::ST_OFF_WAIT;
						timer_load = 1'b1;
					end
				end
			end
			tfrl_pkg::ST_OFF_WAIT: begin
				if (!retry_left) begin
					nxt_state = tfrl_pkg::ST_LATCHED;
				end else if (timer_done) begin
					nxt_state  = tfrl_pkg::ST_RESTART;
					timer_load = 1'b1;
					tries_inc  = 1'b1;
				end
			end
			tfrl_pkg::ST_RESTART: begin
				// Spacing runs from the start of this attempt
				if (restart_ok && !hot_fault) begin
					nxt_state = tfrl_pkg::ST_RUN;
				end else if (timer_done && !retry_left) begin
					// Last attempt had its whole slot to succeed
					nxt_state = tfrl_pkg::ST_LATCHED;
				end else if (timer_done) begin
					timer_load = 1'b1;
					tries_inc  = 1'b1;
				end
			end
			tfrl_pkg::ST_LATCHED: begin
				if (clear_req) begin
					nxt_state = tfrl_pkg::ST_RUN;
				end
			end
			default: nxt_state = tfrl_pkg::ST_LATCHED;
		endcase
		// Off command, bias loss or another fault end endless retries
		if ((state_ff == tfrl_pkg::ST_OFF_WAIT ||
		     state_ff == tfrl_pkg::ST_RESTART) &&
		    (!on_cmd || !bias_ok || other_fault)) begin
			nxt_state = tfrl_pkg::ST_LATCHED;
			// No attempt may start on the way to latch
			timer_load = 1'b0;
			tries_inc  = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state_ff <= tfrl_pkg::ST_RUN;
		end else begin
			state_ff <= nxt_state;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			tries_ff <= 3'h0;
		end else if (tries_clr) begin
			tries_ff <= 3'h0;
		end else if (tries_inc && tries_ff != tfrl_pkg::RETRY_FOREVER) begin
			tries_ff <= tries_ff + 3'h1;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	// Follows the next state so the pin moves with the state change
	always_ff @(posedge clk) begin
		if (rst) begin
			out_enable <= 1'b1;
		end else begin
			out_enable <= (nxt_state == tfrl_pkg::ST_RUN) ||
				(nxt_state == tfrl_pkg::ST_RUN_WAIT) ||
				(nxt_state == tfrl_pkg::ST_RESTART);
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			restart_stb <= 1'b0;
		end else begin
			restart_stb <= tries_inc;
		end
	end

	// Set wins over clear
	always_ff @(posedge clk) begin
		if (rst) begin
			hot_fault_flag <= 1'b0;
		end else if (hot_fault && resp != tfrl_pkg::RESP_IGNORE) begin
			hot_fault_flag <= 1'b1;
		end else if (clear_req) begin
			hot_fault_flag <= 1'b0;
		end
	end
endmodule

// ==== verif/tfrl_tick_model.sv ====
/*
 Delay-unit timer model: a one-cycle tick every PER clocks.
 Assumes clk free-running and rst synchronous, active high.
*/
`timescale 1ns/1ns
module tfrl_tick_model #(parameter int PER = 3) (
	input  wire logic clk,
	input  wire logic rst,
	output logic      unit_tick
);
	logic [7:0] cnt_ff;

	// Short unit keeps the 8-unit cases cheap
	always_ff @(posedge clk) begin
		if (rst || cnt_ff == 8'(PER - 1))
			cnt_ff <= 8'h00;
		else
			cnt_ff <= cnt_ff + 8'h01;
	end

	always_ff @(posedge clk) begin
		unit_tick <= !rst && cnt_ff == 8'(PER - 1);
	end
endmodule

// ==== verif/tfrl_top_properties.sv ====
/*
 Port checker for tfrl_top.
 Assumes it is bound to tfrl_top and sees its ports only.
*/
`timescale 1ns/1ns
module tfrl_top_properties (
	input wire logic        clk,
	input wire logic        rst,
	input wire logic        wr_stb,
	input wire logic        rd_stb,
	input wire logic [7:0]  cmd,
	input wire logic [15:0] rdata,
	input wire logic        ack,
	input wire logic        hot_fault,
	input wire logic        on_cmd,
	input wire logic        bias_ok,
	input wire logic        other_fault,
	input wire logic        clear_hot_bit,
	input wire logic        out_enable,
	input wire logic        restart_stb
);
	// ------------------------------------------------------------
	// Helpers and properties
	// ------------------------------------------------------------
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	logic map;
	logic stb;
	// Mapped codes are 0x50 to 0x53
	assign map = cmd[7:2] == 6'h14;
	assign stb = wr_stb || rd_stb;

	AST_ACK_MAP: assert property (stb && map |=> ack)
		else $error("no ack on mapped code");
	AST_ACK_UNMAP: assert property (stb && !map |=> !ack)
		else $error("ack on unmapped code");
	AST_ACK_CAUSE: assert property (ack |-> $past(stb) && $past(map))
		else $error("ack without request");
	AST_RD_ZERO: assert property (rd_stb && !map |=> rdata == 16'h0000)
		else $error("unmapped read not zero");
	AST_RST_VAL: assert property ($past(rst) |-> out_enable && !ack)
		else $error("bad state after reset");
	AST_RS_PULSE: assert property (restart_stb |=> !restart_stb)
		else $error("restart pulse too long");
	AST_RS_ON: assert property (restart_stb |-> out_enable)
		else $error("restart without output on");
	AST_CLR: assert property (clear_hot_bit && bias_ok && on_cmd &&
		!other_fault && !hot_fault |=> ##[0:2] out_enable)
		else $error("clear did not restore output");

	C_RESTART: cover property (restart_stb);
	C_READ: cover property (rd_stb && map ##1 ack);
	C_OFF: cover property ($fell(out_enable));
endmodule

// ==== verif/tfrl_top_tb.sv ====
/*
 Self-checking bench for tfrl_top with a delay-unit timer model.
 Assumes inputs change at the falling edge; PER sets the unit length.
*/
`timescale 1ns/1ns
module tfrl_top_tb;
	typedef struct {logic rd; logic [15:0] v;} tfrl_exp_t;
	logic clk = 1'b0, rst = 1'b1, wr_stb = 1'b0, rd_stb = 1'b0;
	logic temp_valid = 1'b0, hot_fault = 1'b0, restart_ok = 1'b0;
	logic on_cmd = 1'b1, bias_ok = 1'b1, clear_faults = 1'b0;
	logic clear_hot_bit = 1'b0, other_fault = 1'b0, stop_of = 1'b0;
	logic [7:0] cmd = 8'h00;
	logic [15:0] wdata = 16'h0000, temp_now = 16'h0000, rdata, v;
	logic ack, unit_tick, out_enable, restart_stb;
	logic hot_fault_flag, hot_warn_flag, cold_warn_flag, cold_fault_flag;
	int err_total = 0, comparisons = 0, tk = 0, sp = 0, nrs = 0, k;
	tfrl_exp_t exq[$];
	tfrl_exp_t e;

	always #20 clk = ~clk;

	tfrl_tick_model #(.PER(3)) i_tfrl_tick_model (.clk(clk), .rst(rst),
		.unit_tick(unit_tick));
	tfrl_top i_tfrl_top (.clk(clk), .rst(rst), .wr_stb(wr_stb),
		.rd_stb(rd_stb), .cmd(cmd), .wdata(wdata), .rdata(rdata),
		.ack(ack), .temp_now(temp_now), .temp_valid(temp_valid),
		.hot_fault(hot_fault), .unit_tick(unit_tick),
		.restart_ok(restart_ok), .on_cmd(on_cmd), .bias_ok(bias_ok),
		.other_fault(other_fault), .clear_faults(clear_faults),
		.clear_hot_bit(clear_hot_bit), .out_enable(out_enable),
		.restart_stb(restart_stb), .hot_fault_flag(hot_fault_flag),
		.hot_warn_flag(hot_warn_flag), .cold_warn_flag(cold_warn_flag),
		.cold_fault_flag(cold_fault_flag));

	// ------------------------------------------------------------
	// Reporting
	// ------------------------------------------------------------
	task automatic chk(string n, logic [15:0] s, logic [15:0] x);
		comparisons++;
		if (s !== x) begin
			err_total++;
			$display("BAD %s exp %h got %h", n, x, s);
		end
	endtask

	task automatic chk_rd(logic [15:0] x);
		chk("rdata", rdata, x);
	endtask

	// Bounded wait for the n-th attempt; a hang ends the run
	task automatic wt(int n);
		for (int i = 0; i < 3000 && nrs < n; i++)
			@(negedge clk);
		if (nrs < n) begin
			err_total++;
			results();
		end
	endtask

	task results;
		$display("checks %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// ------------------------------------------------------------
	// Drivers
	// ------------------------------------------------------------
	task automatic op(logic w, logic [7:0] c, logic [15:0] d, logic m);
		@(negedge clk);
		wr_stb = w;
		rd_stb = !w;
		cmd = c;
		wdata = d;
		if (m)
			exq.push_back('{!w, d});
		@(negedge clk);
		wr_stb = 1'b0;
		rd_stb = 1'b0;
	endtask

	// Clear by bit, clear command, bias loss or off-on
	task automatic clr(logic [1:0] m);
		@(negedge clk);
		case (m)
		2'h0: clear_hot_bit = 1'b1;
		2'h1: clear_faults = 1'b1;
		2'h2: bias_ok = 1'b0;
		default: on_cmd = 1'b0;
		endcase
		@(negedge clk);
		{clear_hot_bit, clear_faults, bias_ok, on_cmd} = 4'h3;
		repeat (3) @(negedge clk);
		chk("enable", 16'({out_enable, hot_fault_flag}), 16'h0002);
	endtask

	task automatic retry(logic [2:0] n, logic [2:0] t);
		op(1'b1, 8'h50, {10'h002, n, t}, 1'b1);
		sp = 1 << t;
		nrs = 0;
		hot_fault = 1'b1;
		wt((n == 3'h7) ? 9 : int'(n));
		repeat ((1 << t) * 3 + 10) @(negedge clk);
		if (n == 3'h7 && stop_of)
			other_fault = 1'b1;
		else if (n == 3'h7)
			on_cmd = 1'b0;
		k = nrs;
		repeat (40) @(negedge clk);
		chk("attempts", 16'(nrs),
			(n == 3'h7) ? 16'(k) : 16'(n));
		chk("latched", 16'(out_enable), 16'h0000);
		hot_fault = 1'b0;
		other_fault = 1'b0;
		clr((n == 3'h7) ? 2'h3 : n[1:0]);
	endtask

	// ------------------------------------------------------------
	// Monitors
	// ------------------------------------------------------------
	always @(posedge clk) begin
		if (!rst && ack === 1'b1) begin
			if (exq.size() == 0)
				chk("stray ack", 16'h0001, 16'h0000);
			else begin
				e = exq.pop_front();
				if (e.rd)
					chk_rd(e.v);
			end
		end
	end

	always @(posedge clk) begin
		if (restart_stb === 1'b1) begin
			if (nrs > 0)
				chk("spacing", 16'(tk), 16'(sp));
			nrs++;
			tk = 0;
		end
		if (unit_tick === 1'b1)
			tk++;
	end

	initial begin
		repeat (20000) @(posedge clk);
		err_total++;
		results();
	end

	// ------------------------------------------------------------
	// Sequence
	// ------------------------------------------------------------
	initial begin
		void'($urandom(19));
		repeat (4) @(negedge clk);
		rst = 1'b0;
		for (int c = 8'h50; c < 8'h54; c++)
			op(1'b0, 8'(c), (c == 8'h50) ? 16'h0080 : 16'h0000, 1'b1);
		for (int c = 8'h50; c < 8'h54; c++) begin
			v = 16'($urandom());
			op(1'b1, 8'(c), v, 1'b1);
			op(1'b0, 8'(c), (c == 8'h50) ? {8'h00, v[7:0]} : v, 1'b1);
		end
		op(1'b1, 8'h54, 16'hFFFF, 1'b0);
		op(1'b0, 8'h54, 16'h0000, 1'b0);
		chk_rd(16'h0000);
		for (int n = 0; n < 8; n++)
			retry(3'(n), (n == 7) ? 3'h3 : 3'(n % 4));
		// Endless retries ended by another fault
		stop_of = 1'b1;
		retry(3'h7, 3'h1);
		// Attempt that comes up clean returns to run
		op(1'b1, 8'h50, 16'h0098, 1'b1);
		nrs = 0;
		hot_fault = 1'b1;
		wt(1);
		hot_fault = 1'b0;
		restart_ok = 1'b1;
		repeat (30) @(negedge clk);
		chk("recover", 16'({out_enable, 7'(nrs)}), 16'h0081);
		restart_ok = 1'b0;
		clr(2'h1);
		op(1'b1, 8'h50, 16'h0000, 1'b1);
		hot_fault = 1'b1;
		repeat (20) @(negedge clk);
		chk("ignore", 16'({out_enable, hot_fault_flag}), 16'h0002);
		op(1'b1, 8'h50, 16'h0042, 1'b1);
		repeat (4) @(negedge clk);
		chk("run wait", 16'(out_enable), 16'h0001);
		repeat (30) @(negedge clk);
		chk("run end", 16'(out_enable), 16'h0000);
		hot_fault = 1'b0;
		clr(2'h1);
		op(1'b1, 8'h50, 16'h00E8, 1'b1);
		nrs = 0;
		hot_fault = 1'b1;
		repeat (40) @(negedge clk);
		chk("latch", 16'({out_enable, hot_fault_flag,
			7'(nrs)}), 16'h0080);
		hot_fault = 1'b0;
		clr(2'h0);
		op(1'b1, 8'h51, 16'h0040, 1'b1);
		op(1'b1, 8'h52, 16'h0030, 1'b1);
		op(1'b1, 8'h53, 16'h0020, 1'b1);
		temp_now = 16'h0050;
		temp_valid = 1'b1;
		repeat (3) @(negedge clk);
		chk("hot warn", 16'({hot_warn_flag, cold_warn_flag,
			cold_fault_flag, out_enable}), 16'h0009);
		temp_now = 16'h0010;
		repeat (3) @(negedge clk);
		chk("cold", 16'({cold_warn_flag, cold_fault_flag}), 16'h0003);
		chk("queue", 16'(exq.size()), 16'h0000);
		results();
	end
endmodule

bind tfrl_top tfrl_top_properties i_tfrl_top_properties (.clk(clk),
	.rst(rst), .wr_stb(wr_stb), .rd_stb(rd_stb), .cmd(cmd),
	.rdata(rdata), .ack(ack), .hot_fault(hot_fault), .on_cmd(on_cmd),
	.bias_ok(bias_ok), .other_fault(other_fault),
	.clear_hot_bit(clear_hot_bit), .out_enable(out_enable),
	.restart_stb(restart_stb));
